// ---- slmsr_pkg.sv ----
// Constants for the lane map and sync register bank
package slmsr_pkg;

   // Bus geometry: word index is byte address divided by four
   localparam int unsigned WB_ADR_W = 11;
   localparam int unsigned IDX_W = 9;

   // Register indices; byte address is four times the index
   localparam logic [8:0] IDX_SR_CTRL = 9'h03A;
   localparam logic [8:0] IDX_LANE_AB = 9'h082;
   localparam logic [8:0] IDX_LANE_CD = 9'h083;
   localparam logic [8:0] IDX_LANE_EF = 9'h084;
   localparam logic [8:0] IDX_LANE_GH = 9'h085;
   localparam logic [8:0] IDX_SPARE_A = 9'h088;
   localparam logic [8:0] IDX_SPARE_B = 9'h089;
   localparam logic [8:0] IDX_MODE = 9'h08A;
   localparam logic [8:0] IDX_LMFC_OFS = 9'h08B;
   localparam logic [8:0] IDX_FRAME_OFS = 9'h08C;
   localparam logic [8:0] IDX_DIVIDED_CLOCK_OUTPUT = 9'h0F8;
   localparam logic [8:0] IDX_RSV_F9 = 9'h0F9;
   localparam logic [8:0] IDX_XFER = 9'h0FF;
   localparam logic [8:0] IDX_IRQ_STAT = 9'h100;
   localparam logic [8:0] IDX_IRQ_MASK = 9'h101;

   // Values after reset
   localparam logic [7:0] RST_LANE_AB = 8'h10;
   localparam logic [7:0] RST_LANE_CD = 8'h32;
   localparam logic [7:0] RST_LANE_EF = 8'h54;
   localparam logic [7:0] RST_LANE_GH = 8'h76;
   localparam logic [7:0] RST_SPARE_A = 8'h67;
   localparam logic [7:0] RST_SPARE_B = 8'hF0;
   localparam logic [7:0] RST_MODE = 8'h20;
   localparam logic [7:0] RST_LMFC_OFS = 8'h00;
   localparam logic [7:0] RST_FRAME_OFS = 8'h00;
   localparam logic [7:0] RST_DIVIDED_CLOCK_OUTPUT = 8'h00;
   localparam logic [7:0] RST_RSV_F9 = 8'h00;
   localparam logic [7:0] RST_XFER = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'hBC;
   localparam logic [7:0] RST_SR_CTRL = 8'h00;

   // Field positions and masks
   localparam int unsigned LANE_LO_LSB = 0;
   localparam int unsigned LANE_HI_LSB = 4;
   localparam logic [7:0] LANE_RW_MASK = 8'h77;
   localparam logic [7:0] MODE_RW_MASK = 8'h33;
   localparam logic [7:0] LMFC_RW_MASK = 8'h1F;
   localparam logic [7:0] MASK_RW_MASK = 8'hBD;
   localparam int unsigned XFER_BIT = 0;
   localparam int unsigned SR_CLR_BIT = 6;
   localparam int unsigned DIV_SEL_BIT = 0;
   localparam int unsigned ST_PLL_BIT = 7;
   localparam int unsigned ST_HOLD_BIT = 3;
   localparam int unsigned ST_SETUP_BIT = 2;
   localparam int unsigned ST_CLK_BIT = 0;

   // Alignment modes
   localparam logic [1:0] MODE_LMFC_ALIGN = 2'b00;
   localparam logic [1:0] MODE_TIMESTAMP = 2'b10;

   // Counts
   localparam logic [1:0] DIVIDED_CLOCK_OUTPUT_LAST = 2'h3;
   localparam int unsigned LMFC_LEN_DEF = 32;
   localparam int unsigned FRAME_LEN_DEF = 8;

endpackage

// ---- slmsr_regs.sv ----
// Lane crossbar, SYSREF alignment and status registers on classic Wishbone
`timescale 1ns/1ps

module slmsr_regs #(
   parameter int unsigned LMFC_LEN = slmsr_pkg::LMFC_LEN_DEF,
   parameter int unsigned FRAME_LEN = slmsr_pkg::FRAME_LEN_DEF
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [slmsr_pkg::WB_ADR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic sysref_in,
   input wire logic pll_unlock_in,
   input wire logic sysref_hold_err_in,
   input wire logic sysref_setup_err_in,
   input wire logic clk_err_in,
   output logic [23:0] lane_map_out,
   output logic [1:0] align_mode_out,
   output logic [4:0] lmfc_phase_out,
   output logic [7:0] frame_phase_out,
   output logic sysref_realign_out,
   output logic sysref_stamp_out,
   output logic div_clk_en_out,
   output logic data_invalid_out,
   output logic irq_out
);

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [7:0] m_ab;
      logic [7:0] m_cd;
      logic [7:0] m_ef;
      logic [7:0] m_gh;
      logic [7:0] spare_a;
      logic [7:0] spare_b;
      logic [7:0] m_mode;
      logic [7:0] m_lmfc;
      logic [7:0] m_frame;
      logic [7:0] divided_clock_output;
      logic [7:0] rsv_f9;
      logic [7:0] xfer;
      logic [7:0] mask;
      logic [7:0] sr_ctrl;
      logic [7:0][2:0] s_lane;
      logic [1:0] s_mode;
      logic [4:0] s_lmfc;
      logic [7:0] s_frame;
      logic sr_meta;
      logic sr_sync;
      logic sr_prev;
      logic pll_meta;
      logic pll_sync;
      logic st_hold;
      logic st_setup;
      logic st_clk;
      logic [4:0] lmfc_cnt;
      logic [7:0] frame_cnt;
      logic realign;
      logic stamp;
      logic [1:0] div_cnt;
      logic div_en;
   } slmsr_state_t;

   slmsr_state_t state_reg;
   slmsr_state_t state_next;

   logic [slmsr_pkg::IDX_W-1:0] idx;
   logic wr_cycle;
   logic [7:0] wbyte;
   logic [7:0] status;
   logic sr_rise;
   logic err_clear;
   logic frame_wrap;

   // True when the current bus write targets the given register index
   function automatic logic wr_hit(input logic [8:0] cur, input logic [8:0] target,
                                   input logic wr);
      wr_hit = wr && (cur == target);
   endfunction

   // Merge a write into a register, touching only writable bits
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                        input logic [7:0] rw);
      merge = (old & ~rw) | (val & rw);
   endfunction

   assign idx = wb_adr_in[slmsr_pkg::WB_ADR_W-1:2];
   assign wr_cycle = wb_cyc_in && wb_stb_in && wb_we_in && !state_reg.ack && wb_sel_in[0];
   assign wbyte = wb_dat_in[7:0];
   assign sr_rise = state_reg.sr_sync && !state_reg.sr_prev;
   assign frame_wrap = (state_reg.frame_cnt == 8'(FRAME_LEN - 1));

   // Status byte: live PLL unlock, sticky SYSREF and clock errors, rest zero
   always_comb begin
      status = 8'h00;
      status[slmsr_pkg::ST_PLL_BIT] = state_reg.pll_sync;
      status[slmsr_pkg::ST_HOLD_BIT] = state_reg.st_hold;
      status[slmsr_pkg::ST_SETUP_BIT] = state_reg.st_setup;
      status[slmsr_pkg::ST_CLK_BIT] = state_reg.st_clk;
   end

   always_comb begin
      state_next = state_reg;
      err_clear = 1'b0;

      // Bus slave: one wait state, ack drops the cycle after it is given
      state_next.ack = wb_cyc_in && wb_stb_in && !state_reg.ack;
      state_next.rdat = 32'h0000_0000;
      if (wb_cyc_in && wb_stb_in && !wb_we_in && !state_reg.ack) begin
         unique case (idx)
            slmsr_pkg::IDX_SR_CTRL: state_next.rdat[7:0] = state_reg.sr_ctrl;
            slmsr_pkg::IDX_LANE_AB: state_next.rdat[7:0] = state_reg.m_ab;
            slmsr_pkg::IDX_LANE_CD: state_next.rdat[7:0] = state_reg.m_cd;
            slmsr_pkg::IDX_LANE_EF: state_next.rdat[7:0] = state_reg.m_ef;
            slmsr_pkg::IDX_LANE_GH: state_next.rdat[7:0] = state_reg.m_gh;
            slmsr_pkg::IDX_SPARE_A: state_next.rdat[7:0] = state_reg.spare_a;
            slmsr_pkg::IDX_SPARE_B: state_next.rdat[7:0] = state_reg.spare_b;
            slmsr_pkg::IDX_MODE: state_next.rdat[7:0] = state_reg.m_mode;
            slmsr_pkg::IDX_LMFC_OFS: state_next.rdat[7:0] = state_reg.m_lmfc;
            slmsr_pkg::IDX_FRAME_OFS: state_next.rdat[7:0] = state_reg.m_frame;
            slmsr_pkg::IDX_DIVIDED_CLOCK_OUTPUT: state_next.rdat[7:0] = state_reg.divided_clock_output;
            slmsr_pkg::IDX_RSV_F9: state_next.rdat[7:0] = state_reg.rsv_f9;
            slmsr_pkg::IDX_XFER: state_next.rdat[7:0] = state_reg.xfer;
            slmsr_pkg::IDX_IRQ_STAT: state_next.rdat[7:0] = status;
            slmsr_pkg::IDX_IRQ_MASK: state_next.rdat[7:0] = state_reg.mask;
            default: state_next.rdat = 32'h0000_0000;
         endcase
      end

      // Master copies of lane, mode and offset registers wait for a transfer; spare, divided clock, mask and control act at once
      if (wr_hit(idx, slmsr_pkg::IDX_LANE_AB, wr_cycle)) begin
         state_next.m_ab = merge(state_reg.m_ab, wbyte, slmsr_pkg::LANE_RW_MASK);
      end
      if (wr_hit(idx, slmsr_pkg::IDX_LANE_CD, wr_cycle)) begin
         state_next.m_cd = merge(state_reg.m_cd, wbyte, slmsr_pkg::LANE_RW_MASK);
      end
      if (wr_hit(idx, slmsr_pkg::IDX_LANE_EF, wr_cycle)) begin
         state_next.m_ef = merge(state_reg.m_ef, wbyte, slmsr_pkg::LANE_RW_MASK);
      end
      if (wr_hit(idx, slmsr_pkg::IDX_LANE_GH, wr_cycle)) begin
         state_next.m_gh = merge(state_reg.m_gh, wbyte, slmsr_pkg::LANE_RW_MASK);
      end
      if (wr_hit(idx, slmsr_pkg::IDX_SPARE_A, wr_cycle)) begin
         state_next.spare_a = wbyte;
      end
      if (wr_hit(idx, slmsr_pkg::IDX_SPARE_B, wr_cycle)) begin
         state_next.spare_b = wbyte;
      end
      if (wr_hit(idx, slmsr_pkg::IDX_MODE, wr_cycle)) begin
         state_next.m_mode = merge(state_reg.m_mode, wbyte, slmsr_pkg::MODE_RW_MASK);
      end
      if (wr_hit(idx, slmsr_pkg::IDX_LMFC_OFS, wr_cycle)) begin
         state_next.m_lmfc = merge(state_reg.m_lmfc, wbyte, slmsr_pkg::LMFC_RW_MASK);
      end
      if (wr_hit(idx, slmsr_pkg::IDX_FRAME_OFS, wr_cycle)) begin
         state_next.m_frame = wbyte;
      end
      if (wr_hit(idx, slmsr_pkg::IDX_DIVIDED_CLOCK_OUTPUT, wr_cycle)) begin
         state_next.divided_clock_output = wbyte;
      end
      if (wr_hit(idx, slmsr_pkg::IDX_RSV_F9, wr_cycle)) begin
         state_next.rsv_f9 = wbyte;
      end
      if (wr_hit(idx, slmsr_pkg::IDX_IRQ_MASK, wr_cycle)) begin
         state_next.mask = merge(state_reg.mask, wbyte, slmsr_pkg::MASK_RW_MASK);
      end
      if (wr_hit(idx, slmsr_pkg::IDX_SR_CTRL, wr_cycle)) begin
         state_next.sr_ctrl = wbyte;
      end

      // Transfer bit: a pending 1 copies masters to slaves, then clears
      if (state_reg.xfer[slmsr_pkg::XFER_BIT]) begin
         state_next.s_lane[0] = state_reg.m_ab[slmsr_pkg::LANE_LO_LSB +: 3];
         state_next.s_lane[1] = state_reg.m_ab[slmsr_pkg::LANE_HI_LSB +: 3];
         state_next.s_lane[2] = state_reg.m_cd[slmsr_pkg::LANE_LO_LSB +: 3];
         state_next.s_lane[3] = state_reg.m_cd[slmsr_pkg::LANE_HI_LSB +: 3];
         state_next.s_lane[4] = state_reg.m_ef[slmsr_pkg::LANE_LO_LSB +: 3];
         state_next.s_lane[5] = state_reg.m_ef[slmsr_pkg::LANE_HI_LSB +: 3];
         state_next.s_lane[6] = state_reg.m_gh[slmsr_pkg::LANE_LO_LSB +: 3];
         state_next.s_lane[7] = state_reg.m_gh[slmsr_pkg::LANE_HI_LSB +: 3];
         state_next.s_mode = state_reg.m_mode[1:0];
         state_next.s_lmfc = state_reg.m_lmfc[4:0];
         state_next.s_frame = state_reg.m_frame;
         state_next.xfer[slmsr_pkg::XFER_BIT] = 1'b0;
      end
      if (wr_hit(idx, slmsr_pkg::IDX_XFER, wr_cycle) && wbyte[slmsr_pkg::XFER_BIT]) begin
         state_next.xfer[slmsr_pkg::XFER_BIT] = 1'b1;
      end

      // SYSREF and PLL lock pins pass two flip-flops first
      state_next.sr_meta = sysref_in;
      state_next.sr_sync = state_reg.sr_meta;
      state_next.sr_prev = state_reg.sr_sync;
      state_next.pll_meta = pll_unlock_in;
      state_next.pll_sync = state_reg.pll_meta;

      // SYSREF errors clear on the falling edge of the clear bit, the clock error does not; a new error wins
      err_clear = state_reg.sr_ctrl[slmsr_pkg::SR_CLR_BIT]
                  && !state_next.sr_ctrl[slmsr_pkg::SR_CLR_BIT];
      if (err_clear) begin
         state_next.st_hold = 1'b0;
         state_next.st_setup = 1'b0;
      end
      if (sysref_hold_err_in) begin
         state_next.st_hold = 1'b1;
      end
      if (sysref_setup_err_in) begin
         state_next.st_setup = 1'b1;
      end
      if (clk_err_in) begin
         state_next.st_clk = 1'b1;
      end

      // Free-running frame and multiframe phase counters
      state_next.realign = 1'b0;
      state_next.stamp = 1'b0;
      if (frame_wrap) begin
         state_next.frame_cnt = 8'h00;
         if (state_reg.lmfc_cnt == 5'(LMFC_LEN - 1)) begin
            state_next.lmfc_cnt = 5'h00;
         end else begin
            state_next.lmfc_cnt = state_reg.lmfc_cnt + 5'h01;
         end
      end else begin
         state_next.frame_cnt = state_reg.frame_cnt + 8'h01;
      end
      if (sr_rise) begin
         if (state_reg.s_mode == slmsr_pkg::MODE_LMFC_ALIGN) begin
            state_next.lmfc_cnt = state_reg.s_lmfc;
            state_next.frame_cnt = state_reg.s_frame;
            state_next.realign = 1'b1;
         end else if (state_reg.s_mode == slmsr_pkg::MODE_TIMESTAMP) begin
            state_next.stamp = 1'b1;
         end
      end

      // Divided clock enable, one pulse every fourth cycle while the select bit is clear
      state_next.div_cnt = state_reg.div_cnt + 2'h1;
      state_next.div_en = (state_reg.div_cnt == slmsr_pkg::DIVIDED_CLOCK_OUTPUT_LAST)
                          && !state_reg.divided_clock_output[slmsr_pkg::DIV_SEL_BIT];
   end

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= '0;
         state_reg.m_ab <= slmsr_pkg::RST_LANE_AB;
         state_reg.m_cd <= slmsr_pkg::RST_LANE_CD;
         state_reg.m_ef <= slmsr_pkg::RST_LANE_EF;
         state_reg.m_gh <= slmsr_pkg::RST_LANE_GH;
         state_reg.spare_a <= slmsr_pkg::RST_SPARE_A;
         state_reg.spare_b <= slmsr_pkg::RST_SPARE_B;
         state_reg.m_mode <= slmsr_pkg::RST_MODE;
         state_reg.m_lmfc <= slmsr_pkg::RST_LMFC_OFS;
         state_reg.m_frame <= slmsr_pkg::RST_FRAME_OFS;
         state_reg.divided_clock_output <= slmsr_pkg::RST_DIVIDED_CLOCK_OUTPUT;
         state_reg.rsv_f9 <= slmsr_pkg::RST_RSV_F9;
         state_reg.xfer <= slmsr_pkg::RST_XFER;
         state_reg.mask <= slmsr_pkg::RST_IRQ_MASK;
         state_reg.sr_ctrl <= slmsr_pkg::RST_SR_CTRL;
         state_reg.s_lane[0] <= slmsr_pkg::RST_LANE_AB[2:0];
         state_reg.s_lane[1] <= slmsr_pkg::RST_LANE_AB[6:4];
         state_reg.s_lane[2] <= slmsr_pkg::RST_LANE_CD[2:0];
         state_reg.s_lane[3] <= slmsr_pkg::RST_LANE_CD[6:4];
         state_reg.s_lane[4] <= slmsr_pkg::RST_LANE_EF[2:0];
         state_reg.s_lane[5] <= slmsr_pkg::RST_LANE_EF[6:4];
         state_reg.s_lane[6] <= slmsr_pkg::RST_LANE_GH[2:0];
         state_reg.s_lane[7] <= slmsr_pkg::RST_LANE_GH[6:4];
         state_reg.s_mode <= slmsr_pkg::RST_MODE[1:0];
         state_reg.s_lmfc <= slmsr_pkg::RST_LMFC_OFS[4:0];
         state_reg.s_frame <= slmsr_pkg::RST_FRAME_OFS;
      end else begin
         state_reg <= state_next;
      end
   end

   // Physical lane n carries the logical lane held in slave field n
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_lane
         assign lane_map_out[3*g +: 3] = state_reg.s_lane[g];
      end
   endgenerate

   assign wb_ack_out = state_reg.ack;
   assign wb_dat_out = state_reg.rdat;
   assign align_mode_out = state_reg.s_mode;
   assign lmfc_phase_out = state_reg.lmfc_cnt;
   assign frame_phase_out = state_reg.frame_cnt;
   assign sysref_realign_out = state_reg.realign;
   assign sysref_stamp_out = state_reg.stamp;
   assign div_clk_en_out = state_reg.div_en;
   assign data_invalid_out = state_reg.st_clk;
   assign irq_out = (state_reg.pll_sync && !state_reg.mask[slmsr_pkg::ST_PLL_BIT])
                    || (state_reg.st_hold && !state_reg.mask[slmsr_pkg::ST_HOLD_BIT])
                    || (state_reg.st_setup && !state_reg.mask[slmsr_pkg::ST_SETUP_BIT])
                    || (state_reg.st_clk && !state_reg.mask[slmsr_pkg::ST_CLK_BIT]);

endmodule

// ---- slmsr_regs_asserts.sv ----
// Port-level concurrent checks for the lane map and sync register bank
`timescale 1ns/1ps
module slmsr_regs_asserts #(
   parameter int unsigned FRAME_LEN = slmsr_pkg::FRAME_LEN_DEF
) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic sysref_in,
   input wire logic clk_err_in,
   input wire logic [1:0] align_mode_out,
   input wire logic [7:0] frame_phase_out,
   input wire logic sysref_realign_out,
   input wire logic sysref_stamp_out,
   input wire logic div_clk_en_out,
   input wire logic data_invalid_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held too long");
   property p_ack_next; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing");
   property p_dat; wb_dat_out[31:8] == 24'h0 && (wb_ack_out || wb_dat_out == 32'h0); endproperty
   a_dat: assert property (p_dat) else $error("read data not zero");
   property p_realign_mode; sysref_realign_out |-> align_mode_out == 2'b00; endproperty
   a_realign_mode: assert property (p_realign_mode) else $error("realign in wrong mode");
   property p_stamp_mode; sysref_stamp_out |-> align_mode_out == 2'b10; endproperty
   a_stamp_mode: assert property (p_stamp_mode) else $error("stamp in wrong mode");
   property p_load; $rose(sysref_in) && align_mode_out == 2'b00 |-> ##[2:4] sysref_realign_out;
   endproperty
   a_load: assert property (p_load) else $error("sysref edge gave no load");
   property p_one; sysref_realign_out || sysref_stamp_out |=> !sysref_realign_out && !sysref_stamp_out;
   endproperty
   a_one: assert property (p_one) else $error("more than one load per edge");
   property p_wrap; frame_phase_out == FRAME_LEN - 1
      |=> sysref_realign_out || sysref_stamp_out || frame_phase_out == 8'h00; endproperty
   a_wrap: assert property (p_wrap) else $error("frame counter did not wrap");
   property p_div; div_clk_en_out |=> !div_clk_en_out [*3]; endproperty
   a_div: assert property (p_div) else $error("divided clock faster than 4");
   property p_sticky; data_invalid_out |=> data_invalid_out; endproperty
   a_sticky: assert property (p_sticky) else $error("clock error flag dropped");
   property p_err_set; clk_err_in |-> ##[1:2] data_invalid_out; endproperty
   a_err_set: assert property (p_err_set) else $error("clock error not flagged");
endmodule
bind slmsr_regs slmsr_regs_asserts #(.FRAME_LEN(FRAME_LEN)) i_chk (
   .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .sysref_in(sysref_in),
   .clk_err_in(clk_err_in), .align_mode_out(align_mode_out), .frame_phase_out(frame_phase_out),
   .sysref_realign_out(sysref_realign_out), .sysref_stamp_out(sysref_stamp_out),
   .div_clk_en_out(div_clk_en_out), .data_invalid_out(data_invalid_out)
);

// ---- slmsr_regs_test.sv ----
// Self-checking testbench for the lane map and sync register bank
`timescale 1ns/1ps
module slmsr_regs_test;
   logic clk_sys_in = 1'b0, nrst_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic [10:0] wb_adr_in = 11'h000;
   logic [3:0] wb_sel_in = 4'hF;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
   logic wb_ack_out, sysref_in = 1'b0, pll_unlock_in = 1'b0, hold_in = 1'b0, setup_in = 1'b0;
   logic clk_err_in = 1'b0, realign, stamp, div_en, invalid, irq;
   logic [23:0] lane_map;
   logic [1:0] mode;
   logic [4:0] lmfc;
   logic [7:0] frame;
   int bad_count = 0;
   int cmp_count = 0;
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
   $display("[ERR] %s expected %h seen %h", nm, exp, got); bad_count++; end end
   always #10 clk_sys_in = ~clk_sys_in;
   slmsr_regs #(.LMFC_LEN(32), .FRAME_LEN(8)) i_dut (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
      .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
      .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .sysref_in(sysref_in),
      .pll_unlock_in(pll_unlock_in), .sysref_hold_err_in(hold_in),
      .sysref_setup_err_in(setup_in), .clk_err_in(clk_err_in), .lane_map_out(lane_map),
      .align_mode_out(mode), .lmfc_phase_out(lmfc), .frame_phase_out(frame),
      .sysref_realign_out(realign), .sysref_stamp_out(stamp), .div_clk_en_out(div_en),
      .data_invalid_out(invalid), .irq_out(irq));
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [8:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= wr;
      wb_adr_in <= {idx, 2'b00};
      wb_dat_in <= {24'h0, wd};
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 20);
      rd = wb_dat_out[7:0];
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      wb_we_in <= 1'b0;
      if (wb_ack_out !== 1'b1) begin
         bad_count++;
         $display("[ERR] bus ack timeout");
         end_of_test();
      end
   endtask
   task automatic wr(input logic [8:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task automatic rchk(input logic [8:0] idx, input logic [7:0] exp, input string nm);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      `CHK(nm, exp, r)
   endtask
   // Raises one event input for a single cycle
   task automatic pulse(input int which);
      @(posedge clk_sys_in);
      if (which == 0) hold_in <= 1'b1; else if (which == 1) setup_in <= 1'b1;
      else clk_err_in <= 1'b1;
      @(posedge clk_sys_in);
      {hold_in, setup_in, clk_err_in} <= 3'b000;
   endtask
   task automatic sysref_chk(input bit want_stamp, input logic [4:0] lm, input logic [7:0] fr);
      int n;
      @(posedge clk_sys_in);
      sysref_in <= 1'b1;
      for (n = 0; n < 10 && (want_stamp ? stamp : realign) !== 1'b1; n++) @(posedge clk_sys_in);
      `CHK("sysref event", 1'b1, want_stamp ? stamp : realign)
      if (!want_stamp) `CHK("lmfc load", lm, lmfc)
      if (!want_stamp) `CHK("frame load", fr, frame)
      sysref_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      if (n >= 10) end_of_test();
   endtask
   task automatic t_reset_values;
      `CHK("lane map out", 24'hFAC688, lane_map)
      rchk(slmsr_pkg::IDX_LANE_AB, 8'h10, "lane ab");
      rchk(slmsr_pkg::IDX_LANE_CD, 8'h32, "lane cd");
      rchk(slmsr_pkg::IDX_LANE_EF, 8'h54, "lane ef");
      rchk(slmsr_pkg::IDX_LANE_GH, 8'h76, "lane gh");
      rchk(slmsr_pkg::IDX_SPARE_A, 8'h67, "spare a");
      rchk(slmsr_pkg::IDX_SPARE_B, 8'hF0, "spare b");
      rchk(slmsr_pkg::IDX_MODE, 8'h20, "mode");
      rchk(slmsr_pkg::IDX_LMFC_OFS, 8'h00, "lmfc ofs");
      rchk(slmsr_pkg::IDX_DIVIDED_CLOCK_OUTPUT, 8'h00, "divided_clock_output");
      rchk(slmsr_pkg::IDX_XFER, 8'h00, "xfer");
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h00, "status");
   endtask
   task automatic t_lane_xfer;
      wr(slmsr_pkg::IDX_LANE_AB, 8'hF7);
      rchk(slmsr_pkg::IDX_LANE_AB, 8'h77, "lane ab unused bits");
      wr(slmsr_pkg::IDX_LANE_AB, 8'h07);
      `CHK("lane map before xfer", 24'hFAC688, lane_map)
      wr(slmsr_pkg::IDX_XFER, 8'h01);
      rchk(slmsr_pkg::IDX_XFER, 8'h00, "xfer self clear");
      `CHK("lane map after xfer", 24'hFAC687, lane_map)
      wr(slmsr_pkg::IDX_LANE_AB, 8'h10);
      wr(slmsr_pkg::IDX_XFER, 8'h00);
      `CHK("xfer zero no effect", 24'hFAC687, lane_map)
      wr(slmsr_pkg::IDX_SPARE_A, 8'h5A);
      rchk(slmsr_pkg::IDX_SPARE_A, 8'h5A, "spare a write");
      wr(slmsr_pkg::IDX_IRQ_STAT, 8'hFF);
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h00, "status read only");
      rchk(9'h1F0, 8'h00, "unmapped");
   endtask
   task automatic t_align;
      wr(slmsr_pkg::IDX_LMFC_OFS, 8'h15);
      wr(slmsr_pkg::IDX_FRAME_OFS, 8'h05);
      wr(slmsr_pkg::IDX_XFER, 8'h01);
      sysref_chk(1'b0, 5'h15, 8'h05);
      wr(slmsr_pkg::IDX_MODE, 8'h22);
      `CHK("mode before xfer", 2'b00, mode)
      wr(slmsr_pkg::IDX_XFER, 8'h01);
      // Slaves load on the ack edge, so look one edge later
      @(posedge clk_sys_in);
      `CHK("mode slave", 2'b10, mode)
      sysref_chk(1'b1, 5'h00, 8'h00);
      wr(slmsr_pkg::IDX_MODE, 8'h20);
      wr(slmsr_pkg::IDX_XFER, 8'h01);
   endtask
   task automatic t_status;
      pulse(0);
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h08, "hold flag");
      pulse(1);
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h0C, "setup flag");
      wr(slmsr_pkg::IDX_SR_CTRL, 8'h40);
      wr(slmsr_pkg::IDX_SR_CTRL, 8'h00);
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h00, "flags cleared");
      pll_unlock_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h80, "pll flag");
      `CHK("irq masked", 1'b0, irq)
      wr(slmsr_pkg::IDX_IRQ_MASK, 8'h3C);
      `CHK("irq unmasked", 1'b1, irq)
      pll_unlock_in <= 1'b0;
      wr(slmsr_pkg::IDX_IRQ_MASK, 8'hBC);
      repeat (4) @(posedge clk_sys_in);
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h00, "pll relocked");
      pulse(2);
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h01, "clock error");
      wr(slmsr_pkg::IDX_SR_CTRL, 8'h40);
      wr(slmsr_pkg::IDX_SR_CTRL, 8'h00);
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h01, "clock error sticky");
      `CHK("data invalid", 1'b1, invalid)
      `CHK("irq clock error", 1'b1, irq)
      // Only a full reset recovers from a clock error
      nrst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      `CHK("invalid after reset", 1'b0, invalid)
      `CHK("irq after reset", 1'b0, irq)
      rchk(slmsr_pkg::IDX_IRQ_STAT, 8'h00, "status after reset");
   endtask
   task automatic t_divided_clock_output;
      int cnt;
      cnt = 0;
      repeat (16) @(posedge clk_sys_in) cnt += (div_en === 1'b1);
      `CHK("div by 4 pulses", 4, cnt)
      wr(slmsr_pkg::IDX_DIVIDED_CLOCK_OUTPUT, 8'hFF);
      rchk(slmsr_pkg::IDX_DIVIDED_CLOCK_OUTPUT, 8'hFF, "divided_clock_output spare");
      cnt = 0;
      repeat (16) @(posedge clk_sys_in) cnt += (div_en === 1'b1);
      `CHK("div unused ratio", 0, cnt)
      wr(slmsr_pkg::IDX_DIVIDED_CLOCK_OUTPUT, 8'h00);
   endtask
   initial begin
      repeat (3) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      t_reset_values();
      t_lane_xfer();
      t_align();
      t_divided_clock_output();
      t_status();
      end_of_test();
   end
endmodule
